/* bench/cwt_top_tb_top.sv */
// self-checking bench for the countdown watchdog, driven through its register port
`timescale 1ns/10ps
module countdown_watchdog_timer_tb_top;
    import cwt_pkg::*;
    logic        clock;       // 50 MHz clock
    logic        rst_n;       // async reset, active low
    logic [5:0]  addr;        // register byte address
    logic [31:0] wr_data;     // write data
    logic        wr_en;       // write strobe
    logic        rd_en;       // read strobe
    logic [31:0] rd_data;     // read data, one cycle after rd_en
    logic        dbg_halt;    // debugger halt level
    logic        restart_req; // restart pulse
    logic        boot_jump;   // jump boot selected
    logic [31:0] boot_pc;     // captured entry address
    logic [31:0] boot_sp;     // captured stack pointer
    int          error_cnt;   // mismatches seen
    int          num_checks;  // comparisons made
    logic [31:0] v1;          // sampled count values
    logic [31:0] v2;
    int          n;           // measured cycle counts

    cwt_top dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .dbg_halt(dbg_halt),
        .restart_req(restart_req), .boot_jump(boot_jump), .boot_pc(boot_pc),
        .boot_sp(boot_sp));

    // free-running clock, 20 ns period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // compare and count; four-state so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask : rd

    // read and compare in one call
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        rd(a, v);
        check(v, exp, what);
    endtask : rdc

    // poll the counter until it shows the target; bounded so a stuck count fails
    task automatic wait_cnt(input logic [31:0] target);
        logic [31:0] v;
        for (int i = 0; i < 400; i++) begin
            rd(CWT_COUNT_OFS, v);
            if (v === target) return;
        end
        check(v, target, "count never reached");
    endtask : wait_cnt

    // cycles until the restart pulse, capped
    task automatic wait_restart(output int cyc);
        for (cyc = 0; cyc < 2000; cyc++) begin
            @(posedge clock);
            #1;
            if (restart_req === 1'b1) return;
        end
    endtask : wait_restart

    // back-to-back reads of the counter give the spacing of two decrements exactly
    task automatic measure(output int per);
        logic [31:0] prev;
        int          t0;
        per = 0;
        t0  = -1;
        @(posedge clock);
        addr  <= CWT_COUNT_OFS;
        rd_en <= 1'b1;
        @(posedge clock);
        #1;
        prev = rd_data;
        for (int i = 0; i < 400; i++) begin
            @(posedge clock);
            #1;
            if (rd_data !== prev) begin
                if (t0 >= 0) begin
                    per = i - t0;
                    break;
                end
                t0   = i;
                prev = rd_data;
            end
        end
        @(posedge clock);
        rd_en <= 1'b0;
    endtask : measure

    // verdict and end of run, the single exit point
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // hang guard: the tests need under two thousand cycles, this allows twenty thousand
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end

    // main sequence
    initial begin
        {addr, wr_data, wr_en, rd_en, dbg_halt} = '0;
        error_cnt  = 0;
        num_checks = 0;
        rst_n      = 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rdc(CWT_LOAD_OFS, 32'h00000000, "load reset");
        rdc(CWT_TICK_OFS, 32'h0000000c, "tick reset");
        // a nonzero word was just read, so its release to zero is visible
        @(posedge clock);
        #1;
        check(rd_data, 32'h00000000, "read data released");
        rdc(CWT_REASON_OFS, 32'h00000000, "reason reset");
        rdc(6'h24, 32'h00000000, "unmapped read");
        $display("test reset done");
        // longest legal timeout: anything above saturates at the cap
        wr(CWT_LOAD_OFS, 32'hffffffff);
        rdc(CWT_LOAD_OFS, 32'h007fffff, "load clamp");
        wr(CWT_LOAD_OFS, 32'h00800000);
        rdc(CWT_LOAD_OFS, 32'h007fffff, "load boundary");
        wr(CWT_LOAD_OFS, 32'h00000100);
        // enabling with the divider stopped loads the timeout and holds it
        wr(CWT_CTRL_OFS, 32'h00000001);
        rdc(CWT_COUNT_OFS, 32'h00000100, "enable load");
        repeat (100) @(posedge clock);
        rdc(CWT_COUNT_OFS, 32'h00000100, "no tick no count");
        // 50 clocks per tick is 1 us at 50 MHz
        wr(CWT_TICK_OFS, 32'h00000232);
        measure(n);
        check(n, 50, "tick spacing");
        wait_cnt(32'h000000fd);
        wr(CWT_CTRL_OFS, 32'h00000000);
        repeat (200) @(posedge clock);
        rdc(CWT_COUNT_OFS, 32'h000000fd, "held when disabled");
        wr(CWT_CTRL_OFS, 32'h00000001);
        rdc(CWT_COUNT_OFS, 32'h00000100, "re-enable load");
        wait_cnt(32'h000000fe);
        wr(CWT_FEED_OFS, 32'h00000000);
        rdc(CWT_COUNT_OFS, 32'h00000100, "feed reload");
        $display("test count done");
        // halt with pause set freezes the count, without pause it runs on
        @(posedge clock);
        dbg_halt <= 1'b1;
        wr(CWT_CTRL_OFS, 32'h00000003);
        rd(CWT_COUNT_OFS, v1);
        repeat (200) @(posedge clock);
        rdc(CWT_COUNT_OFS, v1, "paused");
        wr(CWT_CTRL_OFS, 32'h00000001);
        repeat (200) @(posedge clock);
        rd(CWT_COUNT_OFS, v2);
        check(v2 < v1, 1, "runs without pause");
        @(posedge clock);
        dbg_halt <= 1'b0;
        $display("test pause done");
        // expiry of a two-tick timeout with a zero entry address
        wr(CWT_LOAD_OFS, 32'h00000002);
        wr(CWT_CTRL_OFS, 32'h00000000);
        wr(CWT_CTRL_OFS, 32'h00000001);
        wait_restart(n);
        check(n >= 50 && n <= 110, 1, "expiry time");
        check(boot_jump, 1'b0, "standard boot");
        rdc(CWT_REASON_OFS, 32'h00000001, "timeout cause");
        rdc(CWT_CTRL_OFS, 32'h00000000, "enable cleared");
        wr(CWT_REASON_OFS, 32'h00000001);
        rdc(CWT_REASON_OFS, 32'h00000000, "cause cleared");
        // a feed while disabled must not revive the expired count
        wr(CWT_FEED_OFS, 32'h00000000);
        rdc(CWT_COUNT_OFS, 32'h00000000, "feed ignored when off");
        // scheduled reboot to a given entry point; divider stopped so the load is seen
        wr(CWT_PC_OFS, 32'h10000100);
        wr(CWT_SP_OFS, 32'h20000800);
        rdc(CWT_PC_OFS, 32'h10000100, "entry scratch");
        wr(CWT_TICK_OFS, 32'h00000032);
        wr(CWT_REBOOT_OFS, 32'h00000003);
        rdc(CWT_COUNT_OFS, 32'h00000003, "reboot delay");
        wr(CWT_TICK_OFS, 32'h00000232);
        wait_restart(n);
        check(n <= 200, 1, "reboot time");
        check(boot_jump, 1'b1, "jump boot");
        check(boot_pc, 32'h10000100, "boot entry");
        check(boot_sp, 32'h20000800, "boot stack");
        rdc(CWT_REASON_OFS, 32'h00000001, "reboot cause");
        // forced restart answers in the very next cycle
        wr(CWT_REASON_OFS, 32'h00000003);
        wr(CWT_CTRL_OFS, 32'h80000000);
        #1;
        check(restart_req, 1'b1, "forced restart");
        rdc(CWT_REASON_OFS, 32'h00000002, "forced cause");
        $display("test restart done");
        conclude();
    end
endmodule : countdown_watchdog_timer_tb_top

/* hdl/cwt_tick.sv */
// tick divider: one-cycle enable pulse every div_cycles clocks
`timescale 1ns/10ps
module cwt_tick
    import cwt_pkg::*;
#(
    parameter int DIV_W = CWT_DIV_W
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             run,        // divider running
    input  wire logic [DIV_W-1:0] div_cycles, // clocks per tick
    output logic                  tick        // one-cycle pulse
);
    logic [DIV_W-1:0] div_cnt_r;  // position inside the period
    logic [DIV_W-1:0] div_cnt_nxt;
    logic             tick_r;
    logic             tick_nxt;

    // next count; zero cycles means stopped, so no tick ever comes
    always_comb begin
        div_cnt_nxt = div_cnt_r;
        tick_nxt    = 1'b0;
        if (!run || div_cycles == '0) begin
            div_cnt_nxt = '0;
        end else if (div_cnt_r >= div_cycles - 1'b1) begin
            // also catches a divider shortened while running
            div_cnt_nxt = '0;
            tick_nxt    = 1'b1;
        end else begin
            div_cnt_nxt = div_cnt_r + 1'b1;
        end
    end

    // register the divider state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            tick_r    <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : cwt_tick

/* hdl/cwt_top.sv */
// countdown watchdog: down-counter, feed, restart request and boot scratch
`timescale 1ns/10ps
//
// Contract
// - counter at zero requests chip restart
// - feed reloads the programmed timeout
// - load value capped at 0x7fffff
// - divider makes 1 MHz tick from clock
// - counter readable as remaining microseconds
// - pause counting while debugger halts core
// - sticky flag records watchdog reboot cause
// - nonzero entry address selects jump boot
// - scheduled reboot loads supplied delay
module cwt_top
    import cwt_pkg::*;
#(
    parameter int CNT_W = CWT_CNT_W
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [5:0]  addr,        // register byte address
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,       // write strobe
    input  wire logic        rd_en,       // read strobe
    output logic [31:0]      rd_data,     // valid the cycle after rd_en
    input  wire logic        dbg_halt,    // debugger halting or stepping
    output logic             restart_req, // one-cycle restart pulse
    output logic             boot_jump,   // restart should jump to boot_pc
    output logic [31:0]      boot_pc,
    output logic [31:0]      boot_sp
);
    logic             tick;          // 1 MHz enable pulse
    logic             en_r,      en_nxt;      // watchdog running
    logic             pause_r,   pause_nxt;   // pause on debug
    logic [23:0]      load_r,    load_nxt;    // timeout_load_value
    logic [CNT_W-1:0] cnt_r,     cnt_nxt;     // remaining microseconds
    logic [1:0]       reason_r,  reason_nxt;  // {force, timeout}
    logic [31:0]      pc_r,      pc_nxt;      // stored entry address
    logic [31:0]      sp_r,      sp_nxt;      // stored stack pointer
    logic [8:0]       div_r,     div_nxt;     // clocks per tick
    logic             run_r,     run_nxt;     // tick generator running
    logic             rst_q_r,   rst_q_nxt;   // restart pulse
    logic             jump_r,    jump_nxt;
    logic [31:0]      bpc_r,     bpc_nxt;
    logic [31:0]      bsp_r,     bsp_nxt;
    logic [31:0]      rd_r,      rd_nxt;
    logic             expire;        // counter has reached zero
    logic             force_wr;      // software forces a restart
    logic             do_restart;

    // divide the clock down to the microsecond tick
    cwt_tick #(
        .DIV_W      (CWT_DIV_W)
    ) u_tick (
        .clock      (clock),
        .rst_n      (rst_n),
        .run        (run_r),
        .div_cycles (div_r),
        .tick       (tick)
    );

    assign expire     = en_r && (cnt_r == '0);
    assign force_wr   = wr_en && (addr == CWT_CTRL_OFS) && wr_data[CWT_CTRL_FORCE_BIT];
    assign do_restart = expire || force_wr;

    // next values of the whole register and counter state
    always_comb begin
        en_nxt     = en_r;
        pause_nxt  = pause_r;
        load_nxt   = load_r;
        cnt_nxt    = cnt_r;
        reason_nxt = reason_r;
        pc_nxt     = pc_r;
        sp_nxt     = sp_r;
        div_nxt    = div_r;
        run_nxt    = run_r;
        rst_q_nxt  = 1'b0;
        jump_nxt   = jump_r;
        bpc_nxt    = bpc_r;
        bsp_nxt    = bsp_r;
        // count down one per tick while enabled
        // hold the count while the debugger has the core and pause on debug is set
        if (en_r && tick && cnt_r != '0 && !(pause_r && dbg_halt)) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        // software writes take effect over the decrement
        if (wr_en) begin
            case (addr)
                CWT_CTRL_OFS: begin
                    en_nxt    = wr_data[CWT_CTRL_EN_BIT];
                    pause_nxt = wr_data[CWT_CTRL_PAUSE_BIT];
                    // fresh timeout on enable, never a stale count
                    if (!en_r && wr_data[CWT_CTRL_EN_BIT]) begin
                        cnt_nxt = CNT_W'(load_r);
                    end
                end
                // oversize loads are clamped, not wrapped
                CWT_LOAD_OFS: load_nxt = cwt_sat_load(wr_data);
                CWT_FEED_OFS: begin
                    if (en_r) begin
                        cnt_nxt = CNT_W'(load_r);
                    end
                end
                // write one to clear; a restart below still sets it
                CWT_REASON_OFS: reason_nxt = reason_r & ~wr_data[1:0];
                CWT_PC_OFS:     pc_nxt = wr_data;
                CWT_SP_OFS:     sp_nxt = wr_data;
                CWT_TICK_OFS: begin
                    div_nxt = wr_data[8:0];
                    run_nxt = wr_data[CWT_TICK_RUN_BIT];
                end
                CWT_REBOOT_OFS: begin
                    // supplied delay becomes the initial count
                    load_nxt = cwt_sat_load(wr_data);
                    cnt_nxt  = CNT_W'(cwt_sat_load(wr_data));
                    en_nxt   = 1'b1;
                end
                default: ; // unmapped writes are ignored
            endcase
        end
        // zero count or force requests the restart
        if (do_restart) begin
            rst_q_nxt = 1'b1;
            en_nxt    = 1'b0;
            // record the cause; set wins over a clear
            if (expire) begin
                reason_nxt[CWT_RSN_TMO_BIT] = 1'b1;
            end
            if (force_wr) begin
                reason_nxt[CWT_RSN_FORCE_BIT] = 1'b1;
            end
            jump_nxt = (pc_r != 32'h00000000);
            bpc_nxt  = pc_r;
            bsp_nxt  = sp_r;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_nxt = 32'h00000000;
        if (rd_en) begin
            case (addr)
                CWT_CTRL_OFS:   rd_nxt = {30'h00000000, pause_r, en_r};
                CWT_LOAD_OFS:   rd_nxt = {8'h00, load_r};
                CWT_COUNT_OFS:  rd_nxt = 32'(cnt_r);
                CWT_REASON_OFS: rd_nxt = {30'h00000000, reason_r};
                CWT_PC_OFS:     rd_nxt = pc_r;
                CWT_SP_OFS:     rd_nxt = sp_r;
                CWT_TICK_OFS:   rd_nxt = {22'h000000, run_r, div_r};
                CWT_REBOOT_OFS: rd_nxt = {8'h00, load_r};
                default:        rd_nxt = 32'h00000000;
            endcase
        end
    end

    // register every piece of state; outputs come from here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_r     <= 1'b0;
            pause_r  <= 1'b0;
            load_r   <= CWT_LOAD_RST;
            cnt_r    <= CNT_W'(CWT_CNT_RST);
            reason_r <= 2'h0;
            pc_r     <= CWT_WORD_RST;
            sp_r     <= CWT_WORD_RST;
            div_r    <= CWT_DIV_RST;
            run_r    <= 1'b0;
            rst_q_r  <= 1'b0;
            jump_r   <= 1'b0;
            bpc_r    <= CWT_WORD_RST;
            bsp_r    <= CWT_WORD_RST;
            rd_r     <= CWT_WORD_RST;
        end else begin
            en_r     <= en_nxt;
            pause_r  <= pause_nxt;
            load_r   <= load_nxt;
            cnt_r    <= cnt_nxt;
            reason_r <= reason_nxt;
            pc_r     <= pc_nxt;
            sp_r     <= sp_nxt;
            div_r    <= div_nxt;
            run_r    <= run_nxt;
            rst_q_r  <= rst_q_nxt;
            jump_r   <= jump_nxt;
            bpc_r    <= bpc_nxt;
            bsp_r    <= bsp_nxt;
            rd_r     <= rd_nxt;
        end
    end

    assign rd_data     = rd_r;
    assign restart_req = rst_q_r;
    assign boot_jump   = jump_r;
    assign boot_pc     = bpc_r;
    assign boot_sp     = bsp_r;

    // checks on the watchdog behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_expire;
        en_r && cnt_r == '0;
    endsequence
    sequence s_restart_out;
        restart_req && reason_r[CWT_RSN_TMO_BIT] ##1 !restart_req;
    endsequence

    // zero count gives a single restart pulse
    a_restart_on_zero: assert property (s_expire |=> s_restart_out)
        else $error("expiry did not give a single restart pulse");
    a_feed_reload: assert property (wr_en && addr == CWT_FEED_OFS && en_r && !expire
        |=> cnt_r == CNT_W'($past(load_r)))
        else $error("feed did not reload the timeout");
    a_load_capped: assert property (load_r <= CWT_LOAD_MAX)
        else $error("load value above the limit");
    a_count_read: assert property (rd_en && addr == CWT_COUNT_OFS
        |=> rd_data == 32'($past(cnt_r)))
        else $error("count readback wrong");
    a_pause_debug: assert property (en_r && pause_r && dbg_halt && !wr_en && !expire
        |=> $stable(cnt_r))
        else $error("counter moved while debugger halted");
    // decrement by exactly one per tick
    a_tick_decrement: assert property (en_r && tick && !dbg_halt && !wr_en && !expire
        |=> cnt_r == $past(cnt_r) - 1'b1)
        else $error("counter did not step down by one");
    a_idle_hold: assert property (!en_r && !wr_en |=> $stable(cnt_r))
        else $error("counter moved while disabled");
    a_enable_load: assert property (wr_en && addr == CWT_CTRL_OFS && !en_r
        && wr_data[CWT_CTRL_EN_BIT] && !wr_data[CWT_CTRL_FORCE_BIT]
        |=> en_r && cnt_r == CNT_W'($past(load_r)))
        else $error("enable did not load the timeout");
    a_boot_vector: assert property (restart_req |-> boot_pc == $past(pc_r)
        && boot_sp == $past(sp_r) && boot_jump == ($past(pc_r) != 32'h00000000))
        else $error("boot capture disagrees with stored entry");
    a_force_flag: assert property (force_wr |=> restart_req && reason_r[CWT_RSN_FORCE_BIT])
        else $error("forced restart not recorded");
endmodule : cwt_top

/* inc/cwt_pkg.sv */
// constants shared by the countdown watchdog and its tick divider
package cwt_pkg;
    // register byte offsets, one aligned word each
    localparam logic [5:0] CWT_CTRL_OFS   = 6'h00; // enable, pause on debug, force
    localparam logic [5:0] CWT_LOAD_OFS   = 6'h04; // timeout_load_value
    localparam logic [5:0] CWT_FEED_OFS   = 6'h08; // any write reloads the counter while enabled
    localparam logic [5:0] CWT_COUNT_OFS  = 6'h0c; // remaining microseconds, read only
    localparam logic [5:0] CWT_REASON_OFS = 6'h10; // reboot cause, write one to clear
    localparam logic [5:0] CWT_PC_OFS     = 6'h14; // boot entry address scratch
    localparam logic [5:0] CWT_SP_OFS     = 6'h18; // boot stack pointer scratch
    localparam logic [5:0] CWT_TICK_OFS   = 6'h1c; // tick divider count and run bit
    localparam logic [5:0] CWT_REBOOT_OFS = 6'h20; // scheduled reboot delay

    // field positions
    localparam int CWT_CTRL_EN_BIT    = 0;
    localparam int CWT_CTRL_PAUSE_BIT = 1;
    localparam int CWT_CTRL_FORCE_BIT = 31;
    localparam int CWT_RSN_TMO_BIT    = 0;
    localparam int CWT_RSN_FORCE_BIT  = 1;
    localparam int CWT_TICK_RUN_BIT   = 9;

    // widths and limits
    localparam int          CWT_CNT_W    = 24;
    localparam int          CWT_DIV_W    = 9;
    localparam logic [23:0] CWT_LOAD_MAX = 24'h7fffff;

    // values after reset
    localparam logic [23:0] CWT_LOAD_RST = 24'h000000;
    localparam logic [23:0] CWT_CNT_RST  = 24'h000000;
    localparam logic [8:0]  CWT_DIV_RST  = 9'h00c;
    localparam logic [31:0] CWT_WORD_RST = 32'h00000000;

    // clamp a requested load to the longest legal interval
    function automatic logic [23:0] cwt_sat_load(input logic [31:0] req);
        logic [23:0] res;
        res = (req > {8'h00, CWT_LOAD_MAX}) ? CWT_LOAD_MAX : req[23:0];
        return res;
    endfunction : cwt_sat_load
endpackage : cwt_pkg
